// ==== inc/mprs_cfg.svh ====
// timing constants of the module power and restart sequencer
// assumes a 100 MHz sys_clk; all cycle counts derive from the rate below
`ifndef MPRS_CFG_SVH
`define MPRS_CFG_SVH

`define MPRS_CLK_KHZ 100000
// settle time of the main supply before the first switch-on pulse
`define MPRS_SUPPLY_WAIT_MS 50
`define MPRS_SUPPLY_WAIT_CYC (`MPRS_SUPPLY_WAIT_MS * `MPRS_CLK_KHZ)
// first pulse after supply-on must exceed this
`define MPRS_ON_FIRST_MS 1
`define MPRS_ON_FIRST_CYC (`MPRS_ON_FIRST_MS * `MPRS_CLK_KHZ + 1)
// later pulses, once switched off by command, must exceed this
`define MPRS_ON_LATER_MS 30
`define MPRS_ON_LATER_CYC (`MPRS_ON_LATER_MS * `MPRS_CLK_KHZ + 1)
// firmware silence needed before the emergency restart may be used
`define MPRS_FW_SILENT_MS 5000
`define MPRS_FW_SILENT_CYC (`MPRS_FW_SILENT_MS * `MPRS_CLK_KHZ + 1)
// synchroniser depth and reset level of pin inputs
`define MPRS_SYNC_DEPTH 3
`define MPRS_PIN_RST 1'h0

`endif

// ==== inc/mprs_pkg.sv ====
// types of the module power and restart sequencer
// used by hw/mprs_sequencer.sv
package mprs_pkg;
  typedef enum logic [3:0] {
    MPRS_OFF,
    MPRS_SUPPLY_WAIT,
    MPRS_ON_PULSE,
    MPRS_BOOTING,
    MPRS_READY,
    MPRS_STOPPING,
    MPRS_FAST_PIN,
    MPRS_EMERG,
    MPRS_DOWN
  } mprs_state_e;
  typedef logic [31:0] mprs_cnt_t;
endpackage

// ==== hw/mprs_pin_sync.sv ====
// three-stage synchroniser for pins from the module
// a new level is taken once the second and third stage agree
`timescale 1ns/1ns
`include "mprs_cfg.svh"

module mprs_pin_sync #(
  parameter int W = 2
)(
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic [W-1:0] pinIn, // raw pin levels
  output logic [W-1:0] pinLevel // filtered levels
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      logic [`MPRS_SYNC_DEPTH-1:0] stage_reg;
      logic level_reg;
      always_ff @(posedge sys_clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          stage_reg <= {`MPRS_SYNC_DEPTH{`MPRS_PIN_RST}};
          level_reg <= `MPRS_PIN_RST;
        end
        else
        begin
          stage_reg <= {stage_reg[`MPRS_SYNC_DEPTH-2:0], pinIn[i]};
          if (stage_reg[1] == stage_reg[2])
            level_reg <= stage_reg[2];
        end
      end
      assign pinLevel[i] = level_reg;
    end
  endgenerate
endmodule

// ==== hw/mprs_sequencer.sv ====
// host-side sequencer for power-up, restart and shutdown of a cellular module
// assumes an AT-command layer on sys_clk that sends the switch-off command
// and reports the boot-done notice and firmware activity as one-cycle pulses
//
// What this block does
// - switch-on pulse only after main supply on
// - first pulse after supply-on longer than 1 ms
// - after command switch-off, pulses exceed 30 ms
// - hold emergency restart until indicator goes low
// - emergency restart driven open-drain
// - emergency only after 5 s firmware silence
// - remove supply only with indicator low
// - fast power-down line driven low forces shutdown
`timescale 1ns/1ns
`include "mprs_cfg.svh"

module mprs_sequencer #(
  parameter int unsigned SUPPLY_WAIT_CYC = `MPRS_SUPPLY_WAIT_CYC,
  parameter int unsigned ON_FIRST_CYC = `MPRS_ON_FIRST_CYC,
  parameter int unsigned ON_LATER_CYC = `MPRS_ON_LATER_CYC,
  parameter int unsigned FW_SILENT_CYC = `MPRS_FW_SILENT_CYC
)(
  input wire logic sys_clk, // system clock, 100 MHz
  input wire logic sys_rst, // async reset, active high
  input wire logic reqStart, // pulse: supply on if needed and switch on
  input wire logic reqStop, // pulse: send switch-off command
  input wire logic stopFast, // with reqStop: use the fast command
  input wire logic reqFastPin, // pulse: shut down by fast power-down line
  input wire logic reqEmergency, // pulse: emergency restart
  input wire logic reqCut, // pulse: remove main supply
  input wire logic bootDone, // pulse: boot-done notice seen
  input wire logic fwAlive, // pulse: any answer from firmware
  input wire logic ioSupplyPin, // io supply indicator pin
  input wire logic coreRailPin, // core rail pin
  output logic mainSupplyEn, // main supply switch on
  output logic switchOnPin, // switch-on pulse
  output logic rstPinOut, // emergency restart data, always low
  output logic rstPinOe, // emergency restart pulled low
  output logic fastPdOut, // fast power-down data, always low
  output logic fastPdOe, // fast power-down pulled low
  output logic offCmdSend, // pulse: send switch-off command
  output logic offCmdFast, // with offCmdSend: fast variant
  output logic moduleReady, // module booted, commands allowed
  output logic reqRefused, // pulse: last request not taken
  output logic ioLevelOut, // synchronised io indicator
  output logic coreLevelOut, // synchronised core rail
  output mprs_pkg::mprs_state_e seqState // sequencer state
);
  import mprs_pkg::*;

  mprs_state_e state_reg;
  mprs_cnt_t timer_reg;
  mprs_cnt_t silent_reg;
  logic [1:0] pinLevel;
  logic ioLevel;
  logic coreLevel;
  logic offOnce_reg;
  logic supply_reg;
  logic onPin_reg;
  logic rstOe_reg;
  logic fastOe_reg;
  logic offSend_reg;
  logic offFast_reg;
  logic ready_reg;
  logic refused_reg;
  logic ioOut_reg;
  logic coreOut_reg;
  logic zero_reg;
  logic fwSilent;
  logic emergOk;
  logic taken;

  mprs_pin_sync #(.W(2)) mprs_pin_sync_i (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pinIn({coreRailPin, ioSupplyPin}),
    .pinLevel(pinLevel)
  );
  assign ioLevel = pinLevel[0];
  assign coreLevel = pinLevel[1];

  assign fwSilent = (silent_reg == 32'(FW_SILENT_CYC));
  always_comb
  begin
    emergOk = reqEmergency && fwSilent &&
      (state_reg == MPRS_BOOTING || state_reg == MPRS_READY ||
       state_reg == MPRS_STOPPING);
    taken = emergOk ||
      (reqStart && (state_reg == MPRS_OFF || state_reg == MPRS_DOWN)) ||
      ((reqStop || reqFastPin) && state_reg == MPRS_READY) ||
      (reqCut && state_reg == MPRS_DOWN);
  end

  // firmware silence counter, saturating just past the limit
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      silent_reg <= 32'h0;
    else if (fwAlive || bootDone)
      silent_reg <= 32'h0;
    else if (!fwSilent)
      silent_reg <= silent_reg + 32'h1;
  end

  // main sequencer with its interval timer
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= MPRS_OFF;
      timer_reg <= 32'h0;
      supply_reg <= 1'h0;
      onPin_reg <= 1'h0;
      rstOe_reg <= 1'h0;
      fastOe_reg <= 1'h0;
      offSend_reg <= 1'h0;
      offFast_reg <= 1'h0;
      ready_reg <= 1'h0;
      offOnce_reg <= 1'h0;
    end
    else
    begin
      offSend_reg <= 1'h0;
      if (emergOk)
      begin
        rstOe_reg <= 1'h1;
        ready_reg <= 1'h0;
        state_reg <= MPRS_EMERG;
      end
      else
      begin
        case (state_reg)
          MPRS_OFF:
            if (reqStart)
            begin
              supply_reg <= 1'h1;
              offOnce_reg <= 1'h0;
              timer_reg <= 32'(SUPPLY_WAIT_CYC);
              state_reg <= MPRS_SUPPLY_WAIT;
            end
          MPRS_SUPPLY_WAIT:
            if (timer_reg == 32'h0)
            begin
              onPin_reg <= 1'h1;
              timer_reg <= 32'(ON_FIRST_CYC);
              state_reg <= MPRS_ON_PULSE;
            end
            else
              timer_reg <= timer_reg - 32'h1;
          MPRS_ON_PULSE:
            if (timer_reg == 32'h1)
            begin
              onPin_reg <= 1'h0;
              state_reg <= MPRS_BOOTING;
            end
            else
              timer_reg <= timer_reg - 32'h1;
          MPRS_BOOTING:
            if (bootDone)
            begin
              ready_reg <= 1'h1;
              state_reg <= MPRS_READY;
            end
          MPRS_READY:
            if (reqStop)
            begin
              offSend_reg <= 1'h1;
              offFast_reg <= stopFast;
              ready_reg <= 1'h0;
              state_reg <= MPRS_STOPPING;
            end
            else if (reqFastPin)
            begin
              fastOe_reg <= 1'h1;
              ready_reg <= 1'h0;
              state_reg <= MPRS_FAST_PIN;
            end
          MPRS_STOPPING:
            // no end time is imposed; only the indicator or an emergency restart finishes it
            if (!ioLevel)
            begin
              offOnce_reg <= 1'h1;
              state_reg <= MPRS_DOWN;
            end
          MPRS_FAST_PIN:
            if (!ioLevel)
            begin
              fastOe_reg <= 1'h0;
              state_reg <= MPRS_DOWN;
            end
          MPRS_EMERG:
            // releasing before the indicator falls would abort the restart
            if (!ioLevel)
            begin
              rstOe_reg <= 1'h0;
              state_reg <= MPRS_BOOTING;
            end
          MPRS_DOWN:
            if (reqStart)
            begin
              onPin_reg <= 1'h1;
              timer_reg <= offOnce_reg ? 32'(ON_LATER_CYC) : 32'(ON_FIRST_CYC);
              state_reg <= MPRS_ON_PULSE;
            end
            else if (reqCut && !ioLevel)
            begin
              supply_reg <= 1'h0;
              state_reg <= MPRS_OFF;
            end
          default:
            state_reg <= MPRS_OFF;
        endcase
      end
    end
  end

  // status registers toward the user
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      refused_reg <= 1'h0;
      ioOut_reg <= 1'h0;
      coreOut_reg <= 1'h0;
      zero_reg <= 1'h0;
    end
    else
    begin
      refused_reg <= (reqStart || reqStop || reqFastPin || reqEmergency || reqCut) && !taken;
      ioOut_reg <= ioLevel;
      coreOut_reg <= coreLevel;
      zero_reg <= 1'h0;
    end
  end

  assign mainSupplyEn = supply_reg;
  assign switchOnPin = onPin_reg;
  assign rstPinOut = zero_reg;
  assign rstPinOe = rstOe_reg;
  assign fastPdOut = zero_reg;
  assign fastPdOe = fastOe_reg;
  assign offCmdSend = offSend_reg;
  assign offCmdFast = offFast_reg;
  assign moduleReady = ready_reg;
  assign reqRefused = refused_reg;
  assign ioLevelOut = ioOut_reg;
  assign coreLevelOut = coreOut_reg;
  assign seqState = state_reg;

  // width of the current switch-on pulse, for checking only
  mprs_cnt_t onWidth_reg;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      onWidth_reg <= 32'h0;
    else if (onPin_reg)
      onWidth_reg <= onWidth_reg + 32'h1;
    else
      onWidth_reg <= 32'h0;
  end

  property p_on_after_supply;
    @(posedge sys_clk) disable iff (sys_rst) onPin_reg |-> supply_reg;
  endproperty
  a_on_after_supply: assert property (p_on_after_supply)
    else $error("switch-on pulse without main supply");

  property p_first_width;
    @(posedge sys_clk) disable iff (sys_rst)
      $fell(onPin_reg) && !offOnce_reg |-> onWidth_reg == 32'(ON_FIRST_CYC);
  endproperty
  a_first_width: assert property (p_first_width)
    else $error("first switch-on pulse has wrong width");

  property p_later_width;
    @(posedge sys_clk) disable iff (sys_rst)
      $fell(onPin_reg) && offOnce_reg |-> onWidth_reg == 32'(ON_LATER_CYC);
  endproperty
  a_later_width: assert property (p_later_width)
    else $error("later switch-on pulse has wrong width");

  property p_rst_release;
    @(posedge sys_clk) disable iff (sys_rst) $fell(rstOe_reg) |-> $past(!ioLevel);
  endproperty
  a_rst_release: assert property (p_rst_release)
    else $error("restart released before indicator low");

  property p_rst_stays_released;
    @(posedge sys_clk) disable iff (sys_rst) $fell(rstOe_reg) |-> !rstOe_reg [*8];
  endproperty
  a_rst_stays_released: assert property (p_rst_stays_released)
    else $error("restart reasserted right after release");

  property p_rst_silence;
    @(posedge sys_clk) disable iff (sys_rst) $rose(rstOe_reg) |-> $past(fwSilent);
  endproperty
  a_rst_silence: assert property (p_rst_silence)
    else $error("emergency restart without firmware silence");

  property p_cut_io_low;
    @(posedge sys_clk) disable iff (sys_rst) $fell(supply_reg) |-> $past(!ioLevel);
  endproperty
  a_cut_io_low: assert property (p_cut_io_low)
    else $error("supply removed while indicator high");

  property p_fast_held;
    @(posedge sys_clk) disable iff (sys_rst) fastOe_reg && ioLevel |=> fastOe_reg;
  endproperty
  a_fast_held: assert property (p_fast_held)
    else $error("fast power-down released too early");

  property p_fast_after_boot;
    @(posedge sys_clk) disable iff (sys_rst) $rose(fastOe_reg) |-> $past(ready_reg);
  endproperty
  a_fast_after_boot: assert property (p_fast_after_boot)
    else $error("fast power-down used during boot");

  property p_ready_on_notice;
    @(posedge sys_clk) disable iff (sys_rst) $rose(ready_reg) |-> $past(bootDone);
  endproperty
  a_ready_on_notice: assert property (p_ready_on_notice)
    else $error("ready without boot-done notice");

  property p_cv_boot;
    @(posedge sys_clk) disable iff (sys_rst) $rose(ready_reg);
  endproperty
  c_cv_boot: cover property (p_cv_boot);
  property p_cv_stop;
    @(posedge sys_clk) disable iff (sys_rst) state_reg == MPRS_STOPPING ##1 state_reg == MPRS_DOWN;
  endproperty
  c_cv_stop: cover property (p_cv_stop);
  property p_cv_emerg;
    @(posedge sys_clk) disable iff (sys_rst) $fell(rstOe_reg);
  endproperty
  c_cv_emerg: cover property (p_cv_emerg);
endmodule

// ==== testbench/mprs_module_model.sv ====
// behavioural cellular module: rails, boot notice, shutdown, emergency restart
// assumes sys_clk; all module delays are scaled cycle counts
`timescale 1ns/1ns

module mprs_module_model #(
  parameter int BOOT_CYC = 30,
  parameter int RST_CYC = 40,
  parameter int NOTICE_CYC = 20,
  parameter int STOP_CYC = 30,
  parameter int FAST_CYC = 12
)(
  input wire logic sys_clk, // system clock
  input wire logic mainSupplyEn, // main supply applied
  input wire logic switchOnPin, // switch-on input
  input wire logic rstLevel, // emergency restart wire
  input wire logic fastPdLevel, // fast power-down wire
  input wire logic offCmdSend, // switch-off command
  input wire logic offCmdFast, // fast variant
  output logic ioSupplyPin, // io supply indicator
  output logic coreRailPin, // core rail
  output logic bootDone, // boot-done notice
  output logic [7:0] noticeCnt, // shutdown notices sent
  output logic [7:0] restartCnt // emergency restarts
);
  typedef enum logic [1:0] {MPRS_M_DOWN, MPRS_M_BOOT, MPRS_M_RUN, MPRS_M_STOP} mprs_mphase_e;
  mprs_mphase_e phase = MPRS_M_DOWN;
  int cnt = 0;
  int rstCnt = 0;
  int endCnt;
  logic onPrev = 1'h0;
  logic fastStop = 1'h0;
  assign endCnt = fastStop ? FAST_CYC : STOP_CYC;
  initial
  begin
    {ioSupplyPin, coreRailPin, bootDone} = 3'h0;
    noticeCnt = 8'h00;
    restartCnt = 8'h00;
  end
  always @(posedge sys_clk)
  begin
    onPrev <= switchOnPin;
    bootDone <= 1'h0;
    cnt <= cnt + 1;
    if (!mainSupplyEn)
    begin
      phase <= MPRS_M_DOWN;
      {ioSupplyPin, coreRailPin} <= 2'h0;
      rstCnt <= 0;
    end
    else if (phase != MPRS_M_DOWN && !rstLevel && rstCnt == RST_CYC)
    begin
      // volatile state dropped; a pin still held low starts this again
      restartCnt <= restartCnt + 8'h01;
      {ioSupplyPin, coreRailPin} <= 2'h0;
      phase <= MPRS_M_BOOT;
      cnt <= 0;
      rstCnt <= 0;
    end
    else
    begin
      rstCnt <= rstLevel ? 0 : rstCnt + 1;
      case (phase)
        MPRS_M_DOWN:
          if (switchOnPin && !onPrev)
          begin
            phase <= MPRS_M_BOOT;
            cnt <= 0;
          end
        MPRS_M_BOOT:
        begin
          // fast power-down wire is not looked at while booting
          if (cnt == 8) coreRailPin <= 1'h1;
          if (cnt == 10) ioSupplyPin <= 1'h1;
          if (cnt == BOOT_CYC) bootDone <= 1'h1;
          if (cnt == BOOT_CYC) phase <= MPRS_M_RUN;
        end
        MPRS_M_RUN:
          if (offCmdSend || !fastPdLevel)
          begin
            phase <= MPRS_M_STOP;
            cnt <= 0;
            fastStop <= !offCmdSend || offCmdFast;
          end
        default:
        begin
          // further commands ignored until power-down is reached
          if (!fastStop && cnt == NOTICE_CYC) noticeCnt <= noticeCnt + 8'h01;
          if (cnt == endCnt) ioSupplyPin <= 1'h0;
          if (cnt == endCnt + 2) coreRailPin <= 1'h0;
          if (cnt == endCnt + 2) phase <= MPRS_M_DOWN;
        end
      endcase
    end
  end
endmodule

// ==== testbench/mprs_sequencer_tb.sv ====
// self-checking bench of the sequencer facing the module model
// assumes small count parameters so the whole run stays short
`timescale 1ns/1ns

module mprs_sequencer_tb;
  import mprs_pkg::*;
  localparam int SUPPLY_W = 20;
  localparam int ON_FIRST = 5;
  localparam int ON_LATER = 10;
  localparam int FW_SILENT = 50;
  logic sys_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic reqStart = 1'h0, reqStop = 1'h0, stopFast = 1'h0, reqFastPin = 1'h0;
  logic reqEmergency = 1'h0, reqCut = 1'h0, fwAlive = 1'h0;
  logic bootDone, ioSupplyPin, coreRailPin, mainSupplyEn, switchOnPin;
  logic rstPinOut, rstPinOe, fastPdOut, fastPdOe, offCmdSend, offCmdFast;
  logic moduleReady, reqRefused, ioLevelOut, coreLevelOut;
  logic [7:0] noticeCnt, restartCnt, cntBase;
  mprs_state_e seqState;
  int mismatches = 0;
  int checksDone = 0;
  int n;
  wire logic rstLevel = rstPinOe ? rstPinOut : 1'h1;
  wire logic fastPdLevel = fastPdOe ? fastPdOut : 1'h1;

  mprs_sequencer #(.SUPPLY_WAIT_CYC(SUPPLY_W), .ON_FIRST_CYC(ON_FIRST),
    .ON_LATER_CYC(ON_LATER), .FW_SILENT_CYC(FW_SILENT)) mprs_sequencer_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reqStart(reqStart), .reqStop(reqStop),
    .stopFast(stopFast), .reqFastPin(reqFastPin), .reqEmergency(reqEmergency),
    .reqCut(reqCut), .bootDone(bootDone), .fwAlive(fwAlive), .ioSupplyPin(ioSupplyPin),
    .coreRailPin(coreRailPin), .mainSupplyEn(mainSupplyEn), .switchOnPin(switchOnPin),
    .rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .fastPdOut(fastPdOut), .fastPdOe(fastPdOe),
    .offCmdSend(offCmdSend), .offCmdFast(offCmdFast), .moduleReady(moduleReady),
    .reqRefused(reqRefused), .ioLevelOut(ioLevelOut), .coreLevelOut(coreLevelOut),
    .seqState(seqState));
  mprs_module_model mprs_module_model_i (.sys_clk(sys_clk), .mainSupplyEn(mainSupplyEn),
    .switchOnPin(switchOnPin), .rstLevel(rstLevel), .fastPdLevel(fastPdLevel),
    .offCmdSend(offCmdSend), .offCmdFast(offCmdFast), .ioSupplyPin(ioSupplyPin),
    .coreRailPin(coreRailPin), .bootDone(bootDone), .noticeCnt(noticeCnt),
    .restartCnt(restartCnt));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checksDone++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s saw %0h want %0h", $time, what, seen, exp);
    end
  endtask
  function automatic logic cond(input int k);
    case (k)
      0: return mainSupplyEn === 1'h1;
      1: return switchOnPin === 1'h1;
      2: return switchOnPin === 1'h0;
      3: return moduleReady === 1'h1;
      4: return seqState === MPRS_DOWN;
      5: return seqState === MPRS_BOOTING;
      6: return seqState === MPRS_OFF;
      7: return fastPdOe === 1'h1;
      8: return rstPinOe === 1'h1;
      9: return offCmdSend === 1'h1;
      default: return reqRefused === 1'h1;
    endcase
  endfunction
  task automatic waitfor(input int k, input int lim, output int cnt);
    cnt = 0;
    while (!cond(k) && cnt <= lim)
    begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
    if (cnt > lim) chk(cnt, lim, "wait too long");
  endtask
  task automatic cnt_high(input int k, input int win, output int cnt);
    cnt = 0;
    repeat (win)
    begin
      if (cond(k)) cnt++;
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic req(input int k, input logic fast);
    @(posedge sys_clk);
    stopFast <= fast;
    case (k)
      0: reqStart <= 1'h1;
      1: reqStop <= 1'h1;
      2: reqFastPin <= 1'h1;
      3: reqEmergency <= 1'h1;
      4: reqCut <= 1'h1;
      default: fwAlive <= 1'h1;
    endcase
    @(posedge sys_clk);
    {reqStart, reqStop, reqFastPin, reqEmergency, reqCut, fwAlive} <= 6'h00;
    #1;
  endtask
  task automatic t_start(input int width, input logic fromOff);
    if (fromOff)
    begin
      waitfor(0, 3, n);
      waitfor(1, SUPPLY_W + 5, n);
      chk(n, SUPPLY_W + 1, "supply settle");
    end
    else waitfor(1, 3, n);
    waitfor(2, width + 5, n);
    chk(n, width, "switch-on width");
    req(2, 1'h0);
    cnt_high(10, 3, n);
    chk(n, 1, "fast pin in boot");
    waitfor(3, 60, n);
    chk({ioLevelOut, coreLevelOut}, 2'h3, "rails at ready");
  endtask
  task automatic t_stop(input logic fast);
    cntBase = noticeCnt;
    req(1, fast);
    cnt_high(9, 3, n);
    chk(n, 1, "command pulse");
    chk({offCmdFast, moduleReady}, {fast, 1'h0}, "command kind");
    req(1, 1'h0);
    cnt_high(10, 3, n);
    chk(n, 1, "second stop");
    waitfor(4, 60, n);
    chk(ioLevelOut, 1'h0, "indicator at down");
    chk(noticeCnt - cntBase, fast ? 8'h00 : 8'h01, "notice");
  endtask
  task automatic t_fast_pin();
    cntBase = noticeCnt;
    req(2, 1'h0);
    waitfor(7, 2, n);
    waitfor(4, 60, n);
    chk({fastPdOe, fastPdOut, noticeCnt}, {2'h0, cntBase}, "pin released");
  endtask
  task automatic t_cut(input logic inReady);
    req(4, 1'h0);
    if (inReady) cnt_high(10, 3, n);
    if (inReady) chk({n[1:0], mainSupplyEn}, 3'h3, "cut refused");
    else waitfor(6, 3, n);
  endtask
  task automatic t_emergency();
    cntBase = restartCnt;
    req(5, 1'h0);
    req(3, 1'h0);
    cnt_high(10, 3, n);
    chk(n, 1, "early emergency");
    repeat (FW_SILENT + 2) @(posedge sys_clk);
    req(3, 1'h0);
    waitfor(8, 2, n);
    chk({seqState, rstPinOut}, {MPRS_EMERG, 1'h0}, "restart pulled");
    waitfor(5, 80, n);
    chk({rstPinOe, restartCnt}, {1'h0, cntBase + 8'h01}, "one restart");
    waitfor(3, 60, n);
  endtask
  task automatic final_report();
    if (mismatches == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #400000;
    mismatches++;
    final_report();
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    chk({mainSupplyEn, switchOnPin, rstPinOe, fastPdOe, moduleReady}, 5'h00, "reset out");
    chk(seqState, MPRS_OFF, "reset state");
    sys_rst <= 1'h0;
    req(0, 1'h0);
    t_start(ON_FIRST, 1'h1);
    t_cut(1'h1);
    t_stop(1'h0);
    req(0, 1'h0);
    t_start(ON_LATER, 1'h0);
    t_fast_pin();
    t_cut(1'h0);
    req(0, 1'h0);
    t_start(ON_FIRST, 1'h1);
    t_emergency();
    t_stop(1'h1);
    final_report();
  end
endmodule
